// *** logic/pah_pkg.sv ***
// Package with constants for the pause and address handling block.
package pah_pkg;
    // Reserved pause multicast address, octet 0 in the top byte.
    localparam logic [47:0] PAUSE_ADDR     = 48'h0180c2000001;
    localparam logic [47:0] BCAST_ADDR     = 48'hffffffffffff;
    localparam logic [15:0] PAUSE_OPCODE   = 16'h0001;
    localparam logic [15:0] CTRL_TYPE      = 16'h8808;
    localparam int          ADDR_OCTETS    = 6;
    localparam int          GROUP_BIT      = 40;
    localparam int          LOCAL_BIT      = 41;
    localparam logic [3:0]  HDR_NIBBLES    = 4'hc;
    localparam logic [1:0]  BUF_DEPTH      = 2'h2;
    typedef enum logic [4:0] {
        PAH_IDLE  = 5'b00001,
        PAH_CTRL  = 5'b00010,
        PAH_DATA  = 5'b00100,
        PAH_HOLD  = 5'b01000,
        PAH_DONE  = 5'b10000
    } pah_state_t;
endpackage

// *** logic/pah_buf.sv ***
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module pah_buf #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    logic [W-1:0] mem [0:1];
    logic         wr_ptr;
    logic         rd_ptr;
    logic [1:0]   count;
    logic         push;
    logic         pop;

    // Handshake terms.
    assign in_ready  = (count != pah_pkg::BUF_DEPTH);
    assign out_valid = (count != 2'h0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    // Storage and pointers.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
            mem[0] <= '0;
            mem[1] <= '0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push && !pop)
                count <= count + 2'h1;
            else if (pop && !push)
                count <= count - 2'h1;
        end
    end
endmodule // pah_buf

// *** logic/pah_top.sv ***
// Pause frame source, transmit scheduler and receive address filter.
// Functional notes
// - Pause request sends reserved address, opcode, operand.
// - Received pause holds data frames only.
// - Pause frames sent only in full duplex.
// - Filter accepts the reserved pause multicast address.
// - All-ones destination is broadcast, always accepted.
// - Broadcast origination not required.
// - Classify addresses as individual or group.
// - Distinguish locally and globally administered addresses.
// - Address is six octets, zero to five.
// - Each octet sent least significant bit first.
// - Octets sent from octet zero to five.
`timescale 1ns/1ps
module pah_top (
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic        FULL_DUPLEX,
    input  wire logic        PAUSE_REQ,
    input  wire logic [15:0] PAUSE_OPERAND,
    output logic             PAUSE_ACK,
    input  wire logic        DATA_REQ,
    input  wire logic [47:0] DATA_DEST,
    output logic             DATA_ACK,
    input  wire logic        PAUSE_HOLD,
    input  wire logic [47:0] SRC_ADDR,
    output logic [3:0]       TX_NIBBLE,
    output logic             TX_VALID,
    input  wire logic        TX_READY,
    output logic             TX_LAST,
    output logic             TX_BUSY,
    input  wire logic        RX_START,
    input  wire logic [3:0]  RX_NIBBLE,
    input  wire logic        RX_VALID,
    input  wire logic [47:0] STATION_ADDR,
    output logic             RX_DONE,
    output logic             RX_ACCEPT,
    output logic             RX_BCAST,
    output logic             RX_GROUP,
    output logic             RX_LOCAL,
    output logic             RX_PAUSE_DEST,
    output logic             TX_DEST_GROUP
);
    // ********************************************************
    // Transmit scheduling.
    // ********************************************************
    pah_pkg::pah_state_t state;
    pah_pkg::pah_state_t next_state;
    logic [111:0]        frame;
    logic [5:0]          nib_idx;
    logic [5:0]          last_idx;
    logic                buf_ready;
    logic                fill_valid;
    logic [4:0]          buf_in;
    logic [4:0]          buf_out;
    logic                pause_go;
    logic                data_go;

    // Control frames go out even under hold; a pause needs full duplex.
    // duplex gate
    assign pause_go = PAUSE_REQ && FULL_DUPLEX;
    assign data_go  = DATA_REQ && !PAUSE_HOLD && !pause_go;

    // Next-state choice for the scheduler.
    always_comb
    begin
        next_state = state;
        case (state)
            pah_pkg::PAH_IDLE:
                if (pause_go)
                    next_state = pah_pkg::PAH_CTRL;
                else if (data_go)
                    next_state = pah_pkg::PAH_DATA;
                else if (DATA_REQ)
                    next_state = pah_pkg::PAH_HOLD;
            pah_pkg::PAH_HOLD:
                if (pause_go)
                    next_state = pah_pkg::PAH_CTRL;
                else if (data_go)
                    next_state = pah_pkg::PAH_DATA;
                else if (!DATA_REQ)
                    next_state = pah_pkg::PAH_IDLE;
            pah_pkg::PAH_CTRL,
            pah_pkg::PAH_DATA:
                if (buf_ready && nib_idx == last_idx)
                    next_state = pah_pkg::PAH_DONE;
            default:
                next_state = pah_pkg::PAH_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge CLK)
    begin
        if (!NRST)
            state <= pah_pkg::PAH_IDLE;
        else
            state <= next_state;
    end

    // Frame header latch: destination, source, then type; opcode and operand are held apart.
    // pause frame build
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            frame    <= '0;
            last_idx <= 6'h0;
        end
        else if (state != pah_pkg::PAH_CTRL && state != pah_pkg::PAH_DATA)
        begin
            if (pause_go)
            begin
                // A pause frame is 36 nibbles: addresses, type, opcode, operand.
                frame    <= {pah_pkg::PAUSE_ADDR, SRC_ADDR, pah_pkg::CTRL_TYPE};
                last_idx <= 6'd35;
            end
            else
            begin
                // broadcast passed through
                // A data frame is 24 nibbles: the two addresses only.
                frame    <= {DATA_DEST, SRC_ADDR, 16'h0000};
                last_idx <= 6'd23;
            end
        end
    end

    // Operand kept apart so the opcode and operand follow the header.
    logic [31:0] ctrl_tail;
    always_ff @(posedge CLK)
    begin
        if (!NRST)
            ctrl_tail <= 32'h00000000;
        else if (state == pah_pkg::PAH_IDLE || state == pah_pkg::PAH_HOLD)
            ctrl_tail <= {pah_pkg::PAUSE_OPCODE, PAUSE_OPERAND};
    end

    // Nibble counter advanced as the buffer accepts.
    // Six bits are needed, as a pause frame runs to nibble 35.
    always_ff @(posedge CLK)
    begin
        if (!NRST)
            nib_idx <= 6'h0;
        else if (state == pah_pkg::PAH_CTRL || state == pah_pkg::PAH_DATA)
        begin
            if (buf_ready)
                nib_idx <= nib_idx + 6'h1;
        end
        else
            nib_idx <= 6'h0;
    end

    // Whole header in send order: destination, source, type, opcode, operand.
    // A data frame ends after the source address, so its tail is never read.
    logic [143:0] hdr;
    logic [7:0]   cur_octet;
    logic [4:0]   oct_idx;
    logic [3:0]   tx_nib_sel;

    // Header and control tail joined into one view, octet 0 at the top.
    assign hdr     = {frame, ctrl_tail};
    assign oct_idx = nib_idx[5:1];

    // Pick the octet; octets past the header read as zero.
    // The part-select stays in range for every nibble that a frame reaches.
    // six octets
    always_comb
    begin
        if (oct_idx < 5'd18)
            cur_octet = hdr[143 - 8*oct_idx -: 8];
        else
            cur_octet = 8'h00;
    end

    // Pick the nibble: the low half holds the first bits on the wire.
    // lsb first
    always_comb
    begin
        if (nib_idx[0])
            tx_nib_sel = cur_octet[7:4];
        else
            tx_nib_sel = cur_octet[3:0];
    end

    // Nibbles are offered for the whole frame; the fifth bit marks the last.
    assign fill_valid = (state == pah_pkg::PAH_CTRL || state == pah_pkg::PAH_DATA);
    assign buf_in     = {(nib_idx == last_idx), tx_nib_sel};

    // Buffer between scheduler and media so a stall loses no nibble.
    pah_buf #(
        .W (5)
    ) u_buf (
        .clk       (CLK),
        .nrst      (NRST),
        .in_data   (buf_in),
        .in_valid  (fill_valid),
        .in_ready  (buf_ready),
        .out_data  (buf_out),
        .out_valid (TX_VALID),
        .out_ready (TX_READY)
    );

    // Media side of the buffer; busy also covers nibbles still queued.
    assign TX_NIBBLE = buf_out[3:0];
    assign TX_LAST   = buf_out[4];
    assign TX_BUSY   = fill_valid || TX_VALID;

    // Acknowledge pulses when a frame has been fully handed on.
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            PAUSE_ACK <= 1'b0;
            DATA_ACK  <= 1'b0;
        end
        else
        begin
            PAUSE_ACK <= (next_state == pah_pkg::PAH_DONE) && (state == pah_pkg::PAH_CTRL);
            DATA_ACK  <= (next_state == pah_pkg::PAH_DONE) && (state == pah_pkg::PAH_DATA);
        end
    end

    // Group flag of the outgoing destination, from its first bit.
    // Held until the next frame starts, so it can be read after the ack.
    // first bit group
    always_ff @(posedge CLK)
    begin
        if (!NRST)
            TX_DEST_GROUP <= 1'b0;
        else if (fill_valid && nib_idx == 6'h0)
            TX_DEST_GROUP <= tx_nib_sel[0];
    end

    // ********************************************************
    // Receive destination filter.
    // ********************************************************
    logic [47:0] rx_addr;
    logic [3:0]  rx_cnt;
    logic        rx_full;

    // Nibbles arrive low first; rebuild octet 0 at the top.
    // lsb first
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            rx_addr <= 48'h000000000000;
            rx_cnt  <= 4'h0;
        end
        else if (RX_START)
            rx_cnt <= 4'h0;
        else if (RX_VALID && rx_cnt < 4'd12)
        begin
            rx_addr[47 - 8*rx_cnt[3:1] - (rx_cnt[0] ? 0 : 4) -: 4] <= RX_NIBBLE;
            rx_cnt <= rx_cnt + 4'h1;
        end
    end

    assign rx_full = (rx_cnt == 4'd12);

    // Classification after the sixth octet; one-cycle done pulse.
    logic rx_seen;
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            rx_seen       <= 1'b0;
            RX_DONE       <= 1'b0;
            RX_ACCEPT     <= 1'b0;
            RX_BCAST      <= 1'b0;
            RX_GROUP      <= 1'b0;
            RX_LOCAL      <= 1'b0;
            RX_PAUSE_DEST <= 1'b0;
        end
        else
        begin
            RX_DONE <= rx_full && !rx_seen && !RX_START;
            if (RX_START)
                rx_seen <= 1'b0;
            else if (rx_full && !rx_seen)
            begin
                rx_seen <= 1'b1;
                RX_BCAST      <= (rx_addr == pah_pkg::BCAST_ADDR);
                RX_GROUP      <= rx_addr[pah_pkg::GROUP_BIT];
                RX_LOCAL      <= rx_addr[pah_pkg::LOCAL_BIT];
                RX_PAUSE_DEST <= (rx_addr == pah_pkg::PAUSE_ADDR);
                RX_ACCEPT     <= (rx_addr == pah_pkg::BCAST_ADDR)
                              || (rx_addr == pah_pkg::PAUSE_ADDR)
                              || (rx_addr == STATION_ADDR);
            end
        end
    end
endmodule // pah_top

// *** verification/pah_sink.sv ***
// Remote station model that takes transmitted nibbles, promptly or with stalls.
`timescale 1ns/1ps
module pah_sink (
    input  wire logic       clk,
    input  wire logic       slow,
    input  wire logic [3:0] tx_nibble,
    input  wire logic       tx_valid,
    input  wire logic       tx_last,
    output logic            tx_ready
);
    logic [3:0] q[$];
    int         lasts[$];

    // Store each accepted nibble and the place of each last marker.
    // Ready changes just after the edge.
    always @(posedge clk)
    begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
        begin
            if (tx_last === 1'b1)
                lasts.push_back(q.size());
            q.push_back(tx_nibble);
        end
        #1 tx_ready = slow ? 1'($urandom_range(1, 0)) : 1'b1;
    end

    // Ready stays low until the first edge.
    initial tx_ready = 1'b0;
endmodule // pah_sink

// *** verification/pah_top_asserts.sv ***
// Port checker for the pause and address handling block.
`timescale 1ns/1ps
module pah_top_asserts (
    input wire logic       CLK,
    input wire logic       NRST,
    input wire logic       FULL_DUPLEX,
    input wire logic       DATA_REQ,
    input wire logic       PAUSE_ACK,
    input wire logic       DATA_ACK,
    input wire logic [3:0] TX_NIBBLE,
    input wire logic       TX_VALID,
    input wire logic       TX_READY,
    input wire logic       TX_LAST,
    input wire logic       TX_BUSY,
    input wire logic       RX_DONE,
    input wire logic       RX_ACCEPT,
    input wire logic       RX_BCAST,
    input wire logic       RX_GROUP,
    input wire logic       RX_PAUSE_DEST
);
    // ****************
    // Port properties
    // ****************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    a_pause_full_dup: assert property (PAUSE_ACK |-> FULL_DUPLEX)
        else $error("pause frame finished outside full duplex");
    a_no_fdx_start: assert property (!FULL_DUPLEX && !DATA_REQ && !TX_BUSY && !TX_VALID
        |=> !TX_VALID [*2]) else $error("frame started in half duplex");
    a_pause_ack_pulse: assert property (PAUSE_ACK |=> !PAUSE_ACK)
        else $error("pause ack longer than one cycle");
    a_data_ack_pulse: assert property (DATA_ACK |=> !DATA_ACK)
        else $error("data ack longer than one cycle");
    a_tx_word_held: assert property (TX_VALID && !TX_READY
        |=> TX_VALID && $stable(TX_NIBBLE) && $stable(TX_LAST)) else $error("nibble lost");
    a_rx_done_pulse: assert property (RX_DONE |=> !RX_DONE)
        else $error("receive done longer than one cycle");
    a_bcast_flags: assert property (RX_BCAST |-> RX_GROUP && RX_ACCEPT)
        else $error("broadcast not accepted as group");
    a_pause_dest_ok: assert property (RX_PAUSE_DEST |-> RX_ACCEPT && RX_GROUP && !RX_BCAST)
        else $error("pause address not accepted");
    a_reset_quiet: assert property ($rose(NRST) |-> !TX_VALID && !PAUSE_ACK && !DATA_ACK
        && !RX_DONE) else $error("outputs active after reset");

    c_pause: cover property (PAUSE_ACK);
    c_data: cover property (DATA_ACK);
    c_bcast: cover property (RX_DONE ##1 RX_BCAST);
    c_stall: cover property (TX_VALID && !TX_READY);
endmodule // pah_top_asserts

bind pah_top pah_top_asserts u_chk (.CLK(CLK), .NRST(NRST), .FULL_DUPLEX(FULL_DUPLEX),
    .DATA_REQ(DATA_REQ), .PAUSE_ACK(PAUSE_ACK), .DATA_ACK(DATA_ACK), .TX_NIBBLE(TX_NIBBLE),
    .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_LAST(TX_LAST), .TX_BUSY(TX_BUSY),
    .RX_DONE(RX_DONE), .RX_ACCEPT(RX_ACCEPT), .RX_BCAST(RX_BCAST), .RX_GROUP(RX_GROUP),
    .RX_PAUSE_DEST(RX_PAUSE_DEST));

// *** verification/pah_top_tb.sv ***
// Self-checking bench for the pause and address handling block.
`timescale 1ns/1ps
module pah_top_tb;
    logic        clk = 1'b0, nrst = 1'b0, fdx = 1'b1, preq = 1'b0, dreq = 1'b0;
    logic        hold = 1'b0, rx_start = 1'b0, rx_valid = 1'b0, slow = 1'b0, got;
    logic [15:0] oper = 16'h0;
    logic [47:0] dest = 48'h0, src = 48'h0, stn = 48'h0, v;
    logic [3:0]  rx_nib = 4'h0;
    wire  [3:0]  tx_nib;
    wire  [4:0]  rx_flags;
    wire         p_ack, d_ack, tx_valid, tx_ready, tx_last, busy, rx_done, grp;
    int          n_errors = 0, check_count = 0, cycles = 0;

    pah_top dut (.CLK(clk), .NRST(nrst), .FULL_DUPLEX(fdx), .PAUSE_REQ(preq),
        .PAUSE_OPERAND(oper), .PAUSE_ACK(p_ack), .DATA_REQ(dreq), .DATA_DEST(dest),
        .DATA_ACK(d_ack), .PAUSE_HOLD(hold), .SRC_ADDR(src), .TX_NIBBLE(tx_nib),
        .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_LAST(tx_last), .TX_BUSY(busy),
        .RX_START(rx_start), .RX_NIBBLE(rx_nib), .RX_VALID(rx_valid), .STATION_ADDR(stn),
        .RX_DONE(rx_done), .RX_ACCEPT(rx_flags[4]), .RX_BCAST(rx_flags[3]),
        .RX_GROUP(rx_flags[2]), .RX_LOCAL(rx_flags[1]), .RX_PAUSE_DEST(rx_flags[0]),
        .TX_DEST_GROUP(grp));
    pah_sink sink (.clk(clk), .slow(slow), .tx_nibble(tx_nib), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_ready(tx_ready));

    // ****************
    // Helpers
    // ****************
    // Clock of 25 ns period.
    initial forever #12.5 clk = ~clk;

    // Cut a hang short.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic [47:0] rnd48();
        return {16'($urandom), $urandom};
    endfunction

    // Nibble i of an address on the wire: octet 0 first, low nibble first.
    function automatic logic [3:0] nib_of(input logic [47:0] a, input int i);
        logic [7:0] o;
        o = a[47 - 8 * (i / 2) -: 8];
        return (i % 2) ? o[7:4] : o[3:0];
    endfunction

    function automatic logic [47:0] seq_of(input logic [47:0] a);
        logic [47:0] s;
        for (int i = 0; i < 12; i++)
            s = {s[43:0], nib_of(a, i)};
        return s;
    endfunction

    task automatic check(input logic [47:0] got_v, input logic [47:0] exp_v);
        check_count++;
        if (got_v !== exp_v)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    // Compares twelve captured nibbles from a start place against a wire sequence.
    task automatic check_frame(input int start, input logic [47:0] exp_v);
        for (int i = 0; i < 12; i++)
            v = {v[43:0], sink.q[start + i]};
        check(v, exp_v);
    endtask

    // Holds a request until its ack or the limit; data request kept during a pause send.
    task automatic send(input logic pause, input int limit);
        got = 1'b0;
        preq = pause;
        dreq = dreq | !pause;
        for (int k = 0; k < limit && !got; k++)
        begin
            tick(1);
            got = pause ? (p_ack === 1'b1) : (d_ack === 1'b1);
        end
        preq = 1'b0;
        dreq = dreq & pause;
    endtask

    task automatic wait_idle();
        for (int k = 0; k < 200 && (busy !== 1'b0 || tx_valid !== 1'b0); k++)
            tick(1);
    endtask

    task automatic drain();
        wait_idle();
        tick(2);
        sink.q.delete();
        sink.lasts.delete();
    endtask

    // Waits for the link to go quiet, then checks frame length and the last marker.
    task automatic check_len(input int n);
        wait_idle();
        check(48'(sink.q.size()), 48'(n));
        check(48'(sink.lasts.size() == 1 ? sink.lasts[0] : -1), 48'(n - 1));
    endtask

    // Sends one destination address in nibbles and checks the classification.
    task automatic rx_addr(input logic [47:0] a);
        logic bc;
        logic pd;
        bc = a == pah_pkg::BCAST_ADDR;
        pd = a == pah_pkg::PAUSE_ADDR;
        got = 1'b0;
        rx_start = 1'b1;
        tick(1);
        rx_start = 1'b0;
        for (int i = 0; i < 30 && !got; i++)
        begin
            rx_valid = i < 12;
            rx_nib = (i < 12) ? nib_of(a, i) : ~rx_nib;
            tick(1);
            got = rx_done === 1'b1;
        end
        rx_valid = 1'b0;
        check(48'(got), 48'h1);
        check(48'(rx_flags), 48'({a == stn || bc || pd, bc, a[40], a[41], pd}));
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ****************
    // Test sequence
    // ****************
    initial
    begin
        void'($urandom(32'hb80fe3f1));
        src = rnd48() & ~48'h010000000000;
        stn = rnd48() & ~48'h010000000000;
        oper = 16'($urandom);
        tick(4);
        nrst = 1'b1;
        slow = 1'b1;
        send(1'b1, 400);
        check(48'(got), 48'h1);
        check_frame(0, 48'h10082c000010);
        check(48'(grp), 48'h1);
        check_len(36);
        check_frame(24, seq_of({pah_pkg::CTRL_TYPE, pah_pkg::PAUSE_OPCODE, oper}));
        $display("test pause frame done");
        drain();
        fdx = 1'b0;
        send(1'b1, 80);
        check(48'(got), 48'h0);
        check(48'(sink.q.size()), 48'h0);
        fdx = 1'b1;
        $display("test half duplex done");
        hold = 1'b1;
        dreq = 1'b1;
        dest = rnd48();
        send(1'b1, 400);
        check(48'(got), 48'h1);
        check_frame(0, seq_of(pah_pkg::PAUSE_ADDR));
        drain();
        tick(20);
        check(48'(sink.q.size()), 48'h0);
        dest = pah_pkg::BCAST_ADDR;
        hold = 1'b0;
        for (int n = 0; n < 8; n++)
        begin
            slow = n[0];
            send(1'b0, 400);
            check(48'(got), 48'h1);
            check_frame(0, seq_of(dest));
            check(48'(grp), 48'(dest[40]));
            check_len(24);
            drain();
            dest = rnd48();
        end
        $display("test data frames done");
        rx_addr(pah_pkg::PAUSE_ADDR);
        rx_addr(pah_pkg::BCAST_ADDR);
        rx_addr(stn);
        for (int n = 0; n < 6; n++)
            rx_addr(rnd48() & ~48'h010000000000);
        $display("test receive filter done");
        finish_test();
    end
endmodule // pah_top_tb
